// File: hw/lrc_pkg.sv
package lrc_pkg;
  // panel geometry
  localparam logic [8:0] PANEL_LINES = 9'd480;
  localparam logic [8:0] EXP_LINES = 9'd475;
  localparam logic [8:0] SRC_LINES_200 = 9'd200;
  localparam logic [8:0] SRC_LINES_350 = 9'd350;
  localparam logic [8:0] SRC_LINES_400 = 9'd400;
  localparam logic [8:0] SRC_LINES_480 = 9'd480;
  // source resolution select codes
  localparam logic [1:0] RES_200 = 2'h0;
  localparam logic [1:0] RES_350 = 2'h1;
  localparam logic [1:0] RES_400 = 2'h2;
  localparam logic [1:0] RES_480 = 2'h3;
  // text character rows
  localparam logic [4:0] ROW_LINES = 5'd19;
  localparam logic [4:0] ROW_LAST = 5'd18;
  localparam logic [8:0] FONT_H8 = 9'd8;
  localparam logic [8:0] FONT_H14 = 9'd14;
  localparam logic [8:0] FONT_H16 = 9'd16;
  localparam logic [8:0] FONT_H19 = 9'd19;
  localparam logic [4:0] TOP_PAD8 = 5'd1;
  localparam logic [4:0] TOP_PAD14 = 5'd2;
  localparam logic [4:0] TOP_PAD16 = 5'd1;
  localparam logic [4:0] GLYPH_SPAN8 = 5'd16;
  localparam logic [4:0] GLYPH_SPAN14 = 5'd14;
  localparam logic [4:0] GLYPH_SPAN16 = 5'd16;
  // graphics replication patterns, two bits per entry, entry 0 lowest
  localparam logic [15:0] PAT_200 = 16'hEEBA;
  localparam logic [27:0] PAT_350 = 28'h9659965;
  localparam logic [3:0] GRP_LAST_200 = 4'h7;
  localparam logic [3:0] GRP_LAST_350 = 4'hD;
  // last column index of a character cell before shrinking
  localparam logic [3:0] CELL_LAST = 4'h8;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  // control register field positions
  localparam int CTRL_COMP_EN = 0;
  localparam int CTRL_TEXT = 1;
  localparam int CTRL_RES_LO = 2;
  localparam int CTRL_AUTO_TEXT = 4;
  localparam int CTRL_CUSTOM_FONT = 5;
  localparam int CTRL_VCENTER = 6;
  localparam int CTRL_GFX_EXP = 7;
  localparam int CTRL_NINE_DOT = 8;
  localparam int CTRL_WIDTH = 9;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  // status register field positions
  localparam int STAT_SRC_LO = 0;
  localparam int STAT_PANEL_LO = 16;
  localparam int STAT_BLANK = 31;
  // vertical sequencer phases
  typedef enum logic [1:0] {
    LRC_TOP,
    LRC_ACTIVE,
    LRC_BOTTOM
  } lrc_phase_t;
endpackage : lrc_pkg

// File: hw/lrc_pix_path.sv
`timescale 1ns/1ps
// horizontal pixel path: drops ninth cell column, blanks pad lines
module lrc_pix_path (
  input wire logic clk,
  input wire logic srst,
  input wire logic lineStart,
  input wire logic shrinkCell,
  input wire logic lineBlank,
  input wire logic [7:0] pixIn,
  input wire logic pixValid,
  output logic [7:0] pixOut,
  output logic pixOutValid
);
  logic [3:0] cellCol; // column inside a nine-wide cell
  logic [3:0] next_cellCol;
  logic dropPix; // ninth column of a cell is discarded
  logic passPix;

  // column counter wraps after the ninth column
  assign next_cellCol = (cellCol == lrc_pkg::CELL_LAST) ? 4'h0
                        : cellCol + 4'h1;
  assign dropPix = shrinkCell && (cellCol == lrc_pkg::CELL_LAST);
  assign passPix = pixValid && !dropPix;

  // column tracking, restarted at every line
  always_ff @(posedge clk) begin
    if (srst || lineStart) begin
      cellCol <= 4'h0;
    end else if (pixValid) begin
      cellCol <= next_cellCol;
    end
  end

  // registered pixel out toward the dithering stage
  always_ff @(posedge clk) begin
    if (srst) begin
      pixOut <= 8'h00;
      pixOutValid <= 1'b0;
    end else begin
      pixOutValid <= passPix;
      pixOut <= lineBlank ? 8'h00 : pixIn;
    end
  end
endmodule : lrc_pix_path

// File: hw/lrc_compensator.sv
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - nine-dot text cells shown eight pixels wide
// - 8x8 font doubled, one top two bottom
// - 8x14 font: two top, three bottom pad
// - 8x16 font: one top, two bottom pad
// - expanded 475 lines centred on 480 when vCenter is set
// - unexpanded 200/350/400 lines may be centred
// - 200-line graphics: 8 to 19 lines
// - 350-line graphics: 14 to 19 lines
// - custom 8x19 font fills 640 by 475
// - disabled: source lines unchanged at top, rest blank below
// - compensation output feeds dithering stage
module lrc_compensator (
  input wire logic clk,
  input wire logic srst,
  input wire logic frameStart,
  input wire logic lineStart,
  input wire logic [7:0] pixIn,
  input wire logic pixValid,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  output logic [8:0] srcLine,
  output logic lineBlank,
  output logic [8:0] panelLine,
  output logic [7:0] pixOut,
  output logic pixOutValid
);
  // two-bit replication count of a graphics pattern entry
  function automatic logic [1:0] rep_count(input logic is350,
                                           input logic [3:0] idx);
    logic [4:0] bitPos;
    bitPos = {idx, 1'b0};
    if (is350) begin
      rep_count = lrc_pkg::PAT_350[bitPos +: 2];
    end else begin
      rep_count = lrc_pkg::PAT_200[bitPos[3:0] +: 2];
    end
  endfunction : rep_count

  // source line count of an unexpanded mode
  function automatic logic [8:0] src_lines(input logic [1:0] res);
    case (res)
      lrc_pkg::RES_200: src_lines = lrc_pkg::SRC_LINES_200;
      lrc_pkg::RES_350: src_lines = lrc_pkg::SRC_LINES_350;
      lrc_pkg::RES_400: src_lines = lrc_pkg::SRC_LINES_400;
      default: src_lines = lrc_pkg::SRC_LINES_480;
    endcase
  endfunction : src_lines

  // control register
  logic [8:0] ctrl; // software configuration
  logic compEn;
  logic textMode;
  logic [1:0] srcRes;
  logic autoText;
  logic customFont;
  logic vCenter;
  logic gfxExp;
  logic nineDot;

  assign compEn = ctrl[lrc_pkg::CTRL_COMP_EN];
  assign textMode = ctrl[lrc_pkg::CTRL_TEXT];
  assign srcRes = ctrl[lrc_pkg::CTRL_RES_LO +: 2];
  assign autoText = ctrl[lrc_pkg::CTRL_AUTO_TEXT];
  assign customFont = ctrl[lrc_pkg::CTRL_CUSTOM_FONT];
  assign vCenter = ctrl[lrc_pkg::CTRL_VCENTER];
  assign gfxExp = ctrl[lrc_pkg::CTRL_GFX_EXP];
  assign nineDot = ctrl[lrc_pkg::CTRL_NINE_DOT];

  // mode decode
  logic textExp; // text rows padded to 19 lines
  logic gfxExpOn; // graphics replication active
  logic is350;
  logic shrinkCell;
  logic [8:0] activeLen; // displayed lines before padding
  logic [8:0] topPad; // blank lines above the image
  logic [8:0] rowFontH; // source lines per text row

  assign textExp = compEn && textMode && (autoText || customFont);
  assign is350 = (srcRes == lrc_pkg::RES_350);
  assign gfxExpOn = compEn && !textMode && gfxExp
                    && (srcRes == lrc_pkg::RES_200 || is350);
  assign shrinkCell = compEn && textMode && autoText && nineDot;
  // expanded modes give 475 lines, others keep the source count
  assign activeLen = (textExp || gfxExpOn) ? lrc_pkg::EXP_LINES
                     : src_lines(srcRes);
  // centring only with compensation on; else image sits at top
  assign topPad = (compEn && vCenter)
                  ? (lrc_pkg::PANEL_LINES - activeLen) >> 1
                  : 9'h000;

  // font height feeding the row base
  always_comb begin
    if (customFont) begin
      rowFontH = lrc_pkg::FONT_H19;
    end else begin
      case (srcRes)
        lrc_pkg::RES_200: rowFontH = lrc_pkg::FONT_H8;
        lrc_pkg::RES_350: rowFontH = lrc_pkg::FONT_H14;
        default: rowFontH = lrc_pkg::FONT_H16;
      endcase
    end
  end

  // vertical sequencer state
  lrc_pkg::lrc_phase_t phase;
  lrc_pkg::lrc_phase_t next_phase;
  logic [8:0] lineCnt; // panel line of the current line
  logic [8:0] next_lineCnt;
  logic [8:0] activeCnt; // line inside the active image
  logic [8:0] next_activeCnt;
  logic [4:0] rowLine; // line inside a 19-line text row
  logic [4:0] next_rowLine;
  logic [8:0] rowBase; // first source line of the text row
  logic [8:0] next_rowBase;
  logic [8:0] srcCnt; // source line for graphics and plain modes
  logic [8:0] next_srcCnt;
  logic [3:0] grpIdx; // entry inside the replication pattern
  logic [3:0] next_grpIdx;
  logic [1:0] repLeft; // repeats left for the current source line
  logic [1:0] next_repLeft;

  // glyph line selection inside a text row
  logic [4:0] padTop;
  logic [4:0] glyphSpan;
  logic [4:0] rowOfs;
  logic inGlyph;
  logic [4:0] glyphLine;

  always_comb begin
    case (srcRes)
      lrc_pkg::RES_200: begin
        padTop = lrc_pkg::TOP_PAD8;
        glyphSpan = lrc_pkg::GLYPH_SPAN8;
      end
      lrc_pkg::RES_350: begin
        padTop = lrc_pkg::TOP_PAD14;
        glyphSpan = lrc_pkg::GLYPH_SPAN14;
      end
      default: begin
        padTop = lrc_pkg::TOP_PAD16;
        glyphSpan = lrc_pkg::GLYPH_SPAN16;
      end
    endcase
  end

  assign rowOfs = rowLine - padTop;
  // custom font uses all 19 lines, others pad above and below
  assign inGlyph = customFont
                   || (rowLine >= padTop && rowOfs < glyphSpan);
  // 8x8 glyph lines are each shown twice
  assign glyphLine = customFont ? rowLine
                     : (srcRes == lrc_pkg::RES_200) ? (rowOfs >> 1)
                     : rowOfs;

  // description of the current line
  logic curBlank;
  logic [8:0] curSrc;
  assign curBlank = (phase != lrc_pkg::LRC_ACTIVE)
                    || (textExp && !inGlyph);
  assign curSrc = textExp ? rowBase + {4'h0, glyphLine} : srcCnt;

  // next-line decode
  logic lastActive;
  logic firstPad;
  logic rowEnd;
  logic repDone;
  logic grpEnd;
  assign lastActive = (activeCnt == activeLen - 9'h001);
  assign firstPad = (topPad == 9'h000);
  assign rowEnd = (rowLine == lrc_pkg::ROW_LAST);
  assign repDone = (repLeft == 2'h1);
  assign grpEnd = is350 ? (grpIdx == lrc_pkg::GRP_LAST_350)
                  : (grpIdx == lrc_pkg::GRP_LAST_200);

  // next state of the vertical sequencer
  always_comb begin
    next_phase = phase;
    next_lineCnt = lineCnt;
    next_activeCnt = activeCnt;
    next_rowLine = rowLine;
    next_rowBase = rowBase;
    next_srcCnt = srcCnt;
    next_grpIdx = grpIdx;
    next_repLeft = repLeft;
    if (frameStart) begin
      // every frame starts from pattern entry 0
      next_phase = firstPad ? lrc_pkg::LRC_ACTIVE : lrc_pkg::LRC_TOP;
      next_lineCnt = 9'h000;
      next_activeCnt = 9'h000;
      next_rowLine = 5'h00;
      next_rowBase = 9'h000;
      next_srcCnt = 9'h000;
      next_grpIdx = 4'h0;
      next_repLeft = rep_count(is350, 4'h0);
    end else if (lineStart) begin
      next_lineCnt = lineCnt + 9'h001;
      case (phase)
        lrc_pkg::LRC_TOP: begin
          // leave padding once topPad lines have gone by
          if (lineCnt + 9'h001 >= topPad) begin
            next_phase = lrc_pkg::LRC_ACTIVE;
          end
        end
        lrc_pkg::LRC_ACTIVE: begin
          next_activeCnt = activeCnt + 9'h001;
          if (lastActive) begin
            next_phase = lrc_pkg::LRC_BOTTOM;
          end
          if (textExp) begin
            // row finished: start the next row at its first line
            if (rowEnd) begin
              next_rowLine = 5'h00;
              next_rowBase = rowBase + rowFontH;
            end else begin
              next_rowLine = rowLine + 5'h01;
            end
          end else if (gfxExpOn) begin
            // repeat a source line, then step the pattern
            if (repDone) begin
              next_srcCnt = srcCnt + 9'h001;
              next_grpIdx = grpEnd ? 4'h0 : grpIdx + 4'h1;
              next_repLeft = rep_count(is350, next_grpIdx);
            end else begin
              next_repLeft = repLeft - 2'h1;
            end
          end else begin
            next_srcCnt = srcCnt + 9'h001;
          end
        end
        lrc_pkg::LRC_BOTTOM: begin
          next_phase = lrc_pkg::LRC_BOTTOM;
        end
        default: begin
          next_phase = lrc_pkg::LRC_BOTTOM;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (srst) begin
      phase <= lrc_pkg::LRC_BOTTOM;
      lineCnt <= 9'h000;
      activeCnt <= 9'h000;
      rowLine <= 5'h00;
      rowBase <= 9'h000;
      srcCnt <= 9'h000;
      grpIdx <= 4'h0;
      repLeft <= 2'h0;
    end else begin
      phase <= next_phase;
      lineCnt <= next_lineCnt;
      activeCnt <= next_activeCnt;
      rowLine <= next_rowLine;
      rowBase <= next_rowBase;
      srcCnt <= next_srcCnt;
      grpIdx <= next_grpIdx;
      repLeft <= next_repLeft;
    end
  end

  // line descriptor outputs, one cycle behind the sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      srcLine <= 9'h000;
      lineBlank <= 1'b1;
      panelLine <= 9'h000;
    end else begin
      srcLine <= curBlank ? 9'h000 : curSrc;
      lineBlank <= curBlank;
      panelLine <= lineCnt;
    end
  end

  // register port decode
  logic hitCtrl;
  logic hitStatus;
  logic [31:0] statusWord;
  logic [31:0] next_rdData;
  assign hitCtrl = (regAddr == lrc_pkg::OFS_CTRL);
  assign hitStatus = (regAddr == lrc_pkg::OFS_STATUS);
  assign statusWord = {lineBlank, 6'h00, panelLine, 7'h00, srcLine};
  assign next_rdData = !regRead ? 32'h0000_0000
                       : hitCtrl ? {23'h000000, ctrl}
                       : hitStatus ? statusWord
                       : 32'h0000_0000;

  // control write
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= lrc_pkg::CTRL_RESET;
    end else if (regWrite && hitCtrl) begin
      ctrl <= regWrData[lrc_pkg::CTRL_WIDTH-1:0];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdData <= 32'h0000_0000;
    end else begin
      regRdData <= next_rdData;
    end
  end

  // pixel path ahead of the dithering stage
  lrc_pix_path u_pix (
    .clk(clk),
    .srst(srst),
    .lineStart(lineStart),
    .shrinkCell(shrinkCell),
    .lineBlank(lineBlank),
    .pixIn(pixIn),
    .pixValid(pixValid),
    .pixOut(pixOut),
    .pixOutValid(pixOutValid)
  );
endmodule : lrc_compensator

// File: dv/lrc_compensator_properties.sv
`timescale 1ns/1ps
// port-level checks for the compensator
module lrc_compensator_properties (
  input wire logic clk,
  input wire logic srst,
  input wire logic frameStart,
  input wire logic lineStart,
  input wire logic [7:0] pixIn,
  input wire logic pixValid,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  input wire logic [8:0] srcLine,
  input wire logic lineBlank,
  input wire logic [8:0] panelLine,
  input wire logic [7:0] pixOut,
  input wire logic pixOutValid
);
  logic [8:0] ctl; // shadow of control register
  logic [3:0] col; // column inside a nine-pixel cell
  wire shrink = ctl[0] & ctl[1] & ctl[4] & ctl[8];
  wire drop = shrink & (col == 4'h8);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // follow control writes and cell columns
  always_ff @(posedge clk) begin
    if (srst) begin
      ctl <= 9'h000;
      col <= 4'h0;
    end else begin
      if (regWrite && regAddr == lrc_pkg::OFS_CTRL) ctl <= regWrData[8:0];
      if (lineStart) col <= 4'h0;
      else if (pixValid) col <= (col == 4'h8) ? 4'h0 : col + 4'h1;
    end
  end
  a_read_idle: assert property (!regRead |=> regRdData == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_ctrl_read: assert property (regRead && regAddr == lrc_pkg::OFS_CTRL
    |=> regRdData == {23'h0, $past(ctl)})
    else $error("control readback wrong");
  a_status_read: assert property (regRead && regAddr == lrc_pkg::OFS_STATUS
    |=> regRdData == {$past(lineBlank), 6'h0, $past(panelLine), 7'h0,
    $past(srcLine)})
    else $error("status readback wrong");
  a_unmapped_read: assert property (regRead && regAddr != 8'h00
    && regAddr != 8'h04 |=> regRdData == 32'h0)
    else $error("unmapped read not zero");
  a_cell_drop: assert property (pixValid && drop |=> !pixOutValid)
    else $error("ninth cell pixel passed");
  a_pix_pass: assert property (pixValid && !drop && !lineBlank
    |=> pixOutValid && pixOut == $past(pixIn))
    else $error("pixel not passed");
  a_pix_blank: assert property (pixValid && !drop && lineBlank
    |=> pixOutValid && pixOut == 8'h00)
    else $error("pad line pixel not blanked");
  a_pix_idle: assert property (!pixValid |=> !pixOutValid)
    else $error("valid without input pixel");
  a_frame_line: assert property (frameStart |-> ##2 panelLine == 9'h000)
    else $error("frame does not restart at line zero");
  a_line_step: assert property (lineStart && !frameStart
    && panelLine < 9'h1DF |-> ##2 panelLine == $past(panelLine) + 9'h001)
    else $error("line did not advance by one");
  a_blank_src: assert property (lineBlank |-> srcLine == 9'h000)
    else $error("blank line with nonzero source line");
endmodule : lrc_compensator_properties

bind lrc_compensator lrc_compensator_properties i_props (.clk(clk),
  .srst(srst), .frameStart(frameStart), .lineStart(lineStart),
  .pixIn(pixIn), .pixValid(pixValid), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .srcLine(srcLine), .lineBlank(lineBlank),
  .panelLine(panelLine), .pixOut(pixOut), .pixOutValid(pixOutValid));

// File: dv/lrc_panel_model.sv
`timescale 1ns/1ps
// panel side: records each line and counts pixels it receives
module lrc_panel_model (
  input wire logic clk,
  input wire logic clrCount,
  input wire logic [8:0] panelLine,
  input wire logic [8:0] srcLine,
  input wire logic lineBlank,
  input wire logic [7:0] pixOut,
  input wire logic pixOutValid
);
  logic [9:0] lineInfo [0:479]; // last blank and source seen per line
  int pixCount = 0; // pixels received
  int pixSum = 0; // sum of pixel values
  // latch line description and accumulate pixels
  always @(posedge clk) begin
    lineInfo[panelLine] <= {lineBlank, srcLine};
    if (clrCount) begin
      pixCount <= 0;
      pixSum <= 0;
    end else if (pixOutValid) begin
      pixCount <= pixCount + 1;
      pixSum <= pixSum + int'(pixOut);
    end
  end
endmodule : lrc_panel_model

// File: dv/test_lrc_compensator.sv
`timescale 1ns/1ps
// register, line-map and pixel tests for the compensator
module test_lrc_compensator;
  logic clk = 1'b0, srst = 1'b1, frameStart = 1'b0, lineStart = 1'b0;
  logic pixValid = 1'b0, regWrite = 1'b0, regRead = 1'b0, clrCount = 1'b0;
  logic [7:0] pixIn = 8'h00, regAddr = 8'h00, pixOut;
  logic [31:0] regWrData = 32'h0, regRdData, rdv;
  logic [8:0] srcLine, panelLine;
  logic lineBlank, pixOutValid;
  int errors = 0, checks = 0;
  logic [9:0] expI [0:479]; // expected {blank, source} per panel line
  int p2 [0:7] = '{2, 2, 3, 2, 2, 3, 2, 3};
  int p3 [0:13] = '{1, 1, 2, 1, 1, 2, 1, 2, 1, 1, 2, 1, 1, 2};
  always #5 clk = ~clk;
  lrc_compensator i_dut (.clk(clk), .srst(srst), .frameStart(frameStart),
    .lineStart(lineStart), .pixIn(pixIn), .pixValid(pixValid),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .srcLine(srcLine),
    .lineBlank(lineBlank), .panelLine(panelLine), .pixOut(pixOut),
    .pixOutValid(pixOutValid));
  lrc_panel_model i_panel (.clk(clk), .clrCount(clrCount),
    .panelLine(panelLine), .srcLine(srcLine), .lineBlank(lineBlank),
    .pixOut(pixOut), .pixOutValid(pixOutValid));
  task test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 rdv = regRdData;
  endtask : rd
  // one panel line, four cycles apart
  task line(input logic first);
    @(posedge clk);
    frameStart <= first;
    lineStart <= !first;
    @(posedge clk);
    frameStart <= 1'b0;
    lineStart <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : line
  // work out the line map, run a frame, compare every line
  task frame(input logic [8:0] c);
    int L, top, s, k, row, r, g;
    logic txt, gx;
    txt = c[0] & c[1] & (c[4] | c[5]);
    gx = c[0] & !c[1] & c[7] & !c[3];
    L = (txt || gx) ? 475 : 200 + 150 * c[2] + 200 * c[3] - 70 * (c[3] & c[2]);
    top = (c[0] & c[6]) ? (480 - L) / 2 : 0;
    s = 0;
    k = 0;
    for (int i = 0; i < 480; i++) expI[i] = 10'h200;
    for (int a = 0; a < L; a++) begin
      row = a / 19;
      r = a % 19;
      g = -1;
      if (gx) begin
        g = s;
        k++;
        if (k == (c[2] ? p3[s % 14] : p2[s % 8])) begin
          k = 0;
          s++;
        end
      end else if (!txt) g = a;
      else if (c[5]) g = row * 19 + r;
      else if (c[3:2] == 2'h0 && r > 0 && r < 17) g = row * 8 + (r - 1) / 2;
      else if (c[3:2] == 2'h1 && r > 1 && r < 16) g = row * 14 + r - 2;
      else if (c[3:2] == 2'h2 && r > 0 && r < 17) g = row * 16 + r - 1;
      if (g >= 0) expI[top + a] = {1'b0, 9'(g)};
    end
    wr(lrc_pkg::OFS_CTRL, {23'h0, c});
    for (int i = 0; i < 480; i++) line(i == 0);
    // let the model latch the last line before reading it back
    #1;
    for (int i = 0; i < 480; i++) cmp("line", {22'h0, expI[i]},
      {22'h0, i_panel.lineInfo[i]});
    $display("test done: frame mode %h", c);
  endtask : frame
  // eighteen pixels on panel line 1, count and sum what arrives
  task pix(input logic [8:0] c, input int n, input int sum);
    wr(lrc_pkg::OFS_CTRL, {23'h0, c});
    line(1'b1);
    line(1'b0);
    clrCount <= 1'b1;
    @(posedge clk);
    clrCount <= 1'b0;
    for (int v = 1; v <= 18; v++) begin
      pixValid <= 1'b1;
      pixIn <= 8'(v);
      @(posedge clk);
    end
    pixValid <= 1'b0;
    repeat (3) @(posedge clk);
    #1 cmp("pixel count", n, i_panel.pixCount);
    cmp("pixel sum", sum, i_panel.pixSum);
    $display("test done: pixels mode %h", c);
  endtask : pix
  // guard against a hang
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd(lrc_pkg::OFS_CTRL);
    cmp("ctrl reset", 32'h0, rdv);
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08);
    cmp("unmapped", 32'h0, rdv);
    wr(lrc_pkg::OFS_CTRL, 32'hFFFFFFFF);
    rd(lrc_pkg::OFS_CTRL);
    cmp("ctrl", 32'h1FF, rdv);
    $display("test done: registers");
    frame(9'h008);
    rd(lrc_pkg::OFS_STATUS);
    cmp("status", 32'h81DF0000, rdv);
    frame(9'h053);
    frame(9'h017);
    frame(9'h01B);
    frame(9'h06B);
    frame(9'h0C1);
    frame(9'h085);
    frame(9'h045);
    frame(9'h04D);
    pix(9'h11B, 16, 144);
    pix(9'h01B, 18, 171);
    pix(9'h05B, 18, 0);
    test_done;
  end
endmodule : test_lrc_compensator
